// File: common/mie_defs.svh
// Constants of the instruction execute core: offsets, encodings and reset values
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH

`define MIE_CTRL_OFF      8'h00
`define MIE_STAT_OFF      8'h04
`define MIE_CTRL_RUN      0
`define MIE_CTRL_RESET    1'b0

`define MIE_A_TIMER       8'h01
`define MIE_A_PCL         8'h02
`define MIE_A_STATUS      8'h03
`define MIE_A_PC_PAGE_BUFFER      8'h04
`define MIE_A_IRQ_ENABLE_REG       8'h05
`define MIE_A_INDIRECT_ADDR_REG       8'h06

`define MIE_ST_C          0
`define MIE_ST_HC         1
`define MIE_ST_Z          2
`define MIE_ST_BS         7
`define MIE_IE_TOF        2
`define MIE_IE_TOE        5

`define MIE_IRQ_VEC       13'h004
`define MIE_PC_RESET      13'h000
`define MIE_BANK1_BASE    4'h8
`define MIE_RF_DEPTH      144

`define MIE_OP_NOP        5'h00
`define MIE_OP_ADD_REG    5'h01
`define MIE_OP_ADD_IMM    5'h02
`define MIE_OP_SUB_REG    5'h03
`define MIE_OP_SUB_IMM    5'h04
`define MIE_OP_INC        5'h05
`define MIE_OP_DEC        5'h06
`define MIE_OP_INC_SZ     5'h07
`define MIE_OP_DEC_SZ     5'h08
`define MIE_OP_ZERO_REG   5'h09
`define MIE_OP_ZERO_ACC   5'h0a
`define MIE_OP_AND_REG    5'h0b
`define MIE_OP_AND_IMM    5'h0c
`define MIE_OP_INVERT     5'h0d
`define MIE_OP_OR_REG     5'h0e
`define MIE_OP_OR_IMM     5'h0f
`define MIE_OP_XOR_REG    5'h10
`define MIE_OP_XOR_IMM    5'h11
`define MIE_OP_BIT_CLR    5'h12
`define MIE_OP_BIT_SET    5'h13
`define MIE_OP_TST_CLR    5'h14
`define MIE_OP_TST_SET    5'h15
`define MIE_OP_MOV_TO_REG 5'h16
`define MIE_OP_MOV_TO_ACC 5'h17
`define MIE_OP_LOAD_IMM   5'h18
`define MIE_OP_SWAP       5'h19
`define MIE_OP_ROT_LEFT   5'h1a
`define MIE_OP_ROT_RIGHT  5'h1b
`define MIE_OP_CALL       5'h1c
`define MIE_OP_JUMP       5'h1d
`define MIE_OP_RET_IMM    5'h1e
`define MIE_OP_RET        5'h1f

`endif

// File: common/mie_pkg.sv
// Types of the instruction execute core
package mie_pkg;

    typedef enum logic [1:0] {
        mie_exec  = 2'b01,
        mie_flush = 2'b10
    } mie_state_type;

    typedef struct packed {
        mie_state_type    state;
        logic [12:0]      pc;
        logic [7:0]       acc;
        logic [7:0]       status;
        logic [4:0]       pc_page_buffer;
        logic [7:0]       irq_enable_reg;
        logic [7:0]       timer;
        logic [7:0]       indirect_addr_reg;
        logic             in_isr;
        logic [1:0]       sp;
        logic [3:0][12:0] stack;
        logic             run;
        logic             wpend;
        logic [7:0]       waddr;
        logic [31:0]      hrdata;
    } mie_regs_type;

endpackage : mie_pkg

// File: dv/mcu_instruction_execute_test.sv
// Self-checking bench: runs short programs and reads the core state over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
`include "mie_defs.svh"

module mcu_instruction_execute_test;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [12:0] prog_addr;
    logic [15:0] prog_data;
    logic [31:0] st;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;

    mie_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .prog_addr(prog_addr), .prog_data(prog_data));
    mie_prog_mem u_mem (.prog_addr(prog_addr), .prog_data(prog_data));

    initial begin
        forever #50 hclk = ~hclk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // A hang in any wait loop ends here
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Enter just after a rising edge; returns just after the data phase edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : xfer

    function automatic logic [15:0] ins(input logic [4:0] op, input logic [10:0] f);
        return {op, f};
    endfunction : ins

    task automatic prog(input logic [12:0] b, input logic [15:0] w[]);
        for (int i = 0; i < w.size(); i++) u_mem.mem[b + 13'(i)] = w[i];
    endtask : prog

    // Restart the core, run until it parks, then compare pc, accumulator and masked flags
    task automatic run_test(input logic [12:0] pc, input logic [7:0] acc,
                            input logic [3:0] fl, input logic [3:0] m);
        int k;
        k = 0;
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b1, `MIE_CTRL_OFF, 32'h1, st);
        do begin
            xfer(1'b0, `MIE_STAT_OFF, 32'h0, st);
            k++;
        end while ((st[12:0] !== pc || st[23:16] !== acc) && k < 300);
        repeat (300) @(posedge hclk);
        xfer(1'b0, `MIE_STAT_OFF, 32'h0, st);
        chk("pc", 32'(st[12:0]), 32'(pc));
        chk("acc", 32'(st[23:16]), 32'(acc));
        chk("flags", 32'(st[27:24] & m), 32'(fl));
        foreach (u_mem.mem[i]) u_mem.mem[i] = 16'h0000;
    endtask : run_test

    task automatic irq_prog(input logic [7:0] en);
        prog(13'h000, '{ins(`MIE_OP_JUMP, 11'h010)});
        // Handler keeps the interrupted accumulator and disarms itself, so one entry only
        prog(13'h004, '{ins(`MIE_OP_MOV_TO_REG, 11'h421), ins(`MIE_OP_LOAD_IMM, 11'h099),
            ins(`MIE_OP_MOV_TO_REG, 11'h422), ins(`MIE_OP_BIT_CLR, 11'h505),
            ins(`MIE_OP_BIT_CLR, 11'h205), ins(`MIE_OP_SWAP, 11'h421),
            ins(`MIE_OP_SWAP, 11'h021), ins(`MIE_OP_RET, 11'h400)});
        // Marker cleared, then a bounded wait longer than one timer wrap before it is read
        prog(13'h010, '{ins(`MIE_OP_LOAD_IMM, 11'h000), ins(`MIE_OP_MOV_TO_REG, 11'h422),
            ins(`MIE_OP_MOV_TO_REG, 11'h423), ins(`MIE_OP_LOAD_IMM, {3'h0, en}),
            ins(`MIE_OP_MOV_TO_REG, 11'h405), ins(`MIE_OP_DEC_SZ, 11'h423),
            ins(`MIE_OP_JUMP, 11'h015), ins(`MIE_OP_MOV_TO_ACC, 11'h022),
            ins(`MIE_OP_JUMP, 11'h018)});
    endtask : irq_prog

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b1, 32'h8, 32'hffff_ffff, st);
        xfer(1'b0, 32'h8, 32'h0, st);
        chk("unmapped", st, 32'h0);
        xfer(1'b1, `MIE_CTRL_OFF, 32'h1, st);
        xfer(1'b0, `MIE_CTRL_OFF, 32'h0, st);
        chk("ctrl", st, 32'h1);
        prog(13'h000, '{ins(`MIE_OP_ZERO_ACC, 11'h0), ins(`MIE_OP_ADD_IMM, 11'h08f),
            ins(`MIE_OP_ADD_IMM, 11'h071), ins(`MIE_OP_JUMP, 11'h003)});
        run_test(13'h003, 8'h00, 4'b0111, 4'b0111);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h005), ins(`MIE_OP_MOV_TO_REG, 11'h420),
            ins(`MIE_OP_LOAD_IMM, 11'h003), ins(`MIE_OP_SUB_REG, 11'h020),
            ins(`MIE_OP_JUMP, 11'h004)});
        run_test(13'h004, 8'h02, 4'b0011, 4'b0111);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h005), ins(`MIE_OP_OR_IMM, 11'h040),
            ins(`MIE_OP_SUB_IMM, 11'h003), ins(`MIE_OP_JUMP, 11'h003)});
        run_test(13'h003, 8'hbe, 4'b0000, 4'b0111);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h08f), ins(`MIE_OP_ADD_IMM, 11'h071),
            ins(`MIE_OP_LOAD_IMM, 11'h010), ins(`MIE_OP_MOV_TO_REG, 11'h420),
            ins(`MIE_OP_INC_SZ, 11'h020), ins(`MIE_OP_DEC, 11'h420),
            ins(`MIE_OP_MOV_TO_ACC, 11'h020), ins(`MIE_OP_JUMP, 11'h007)});
        run_test(13'h007, 8'h0f, 4'b0011, 4'b0111);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h001), ins(`MIE_OP_MOV_TO_REG, 11'h420),
            ins(`MIE_OP_DEC_SZ, 11'h020), ins(`MIE_OP_LOAD_IMM, 11'h055),
            ins(`MIE_OP_ADD_REG, 11'h020), ins(`MIE_OP_JUMP, 11'h005)});
        run_test(13'h005, 8'h01, 4'b0000, 4'b0111);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h000), ins(`MIE_OP_MOV_TO_REG, 11'h420),
            ins(`MIE_OP_BIT_SET, 11'h320), ins(`MIE_OP_TST_SET, 11'h320),
            ins(`MIE_OP_LOAD_IMM, 11'h077), ins(`MIE_OP_TST_CLR, 11'h320),
            ins(`MIE_OP_SWAP, 11'h020), ins(`MIE_OP_JUMP, 11'h007)});
        run_test(13'h007, 8'h80, 4'b0000, 4'b0000);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h081), ins(`MIE_OP_ADD_IMM, 11'h080),
            ins(`MIE_OP_MOV_TO_REG, 11'h420), ins(`MIE_OP_ROT_LEFT, 11'h020),
            ins(`MIE_OP_ROT_RIGHT, 11'h020), ins(`MIE_OP_JUMP, 11'h005)});
        run_test(13'h005, 8'h00, 4'b0001, 4'b0111);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h0ff), ins(`MIE_OP_AND_IMM, 11'h0f0),
            ins(`MIE_OP_MOV_TO_REG, 11'h420), ins(`MIE_OP_LOAD_IMM, 11'h03c),
            ins(`MIE_OP_AND_REG, 11'h020), ins(`MIE_OP_XOR_REG, 11'h020),
            ins(`MIE_OP_INVERT, 11'h020), ins(`MIE_OP_ZERO_REG, 11'h420),
            ins(`MIE_OP_OR_REG, 11'h020), ins(`MIE_OP_XOR_IMM, 11'h00f),
            ins(`MIE_OP_JUMP, 11'h00a)});
        run_test(13'h00a, 8'h00, 4'b0100, 4'b0100);
        prog(13'h000, '{ins(`MIE_OP_CALL, 11'h010), ins(`MIE_OP_CALL, 11'h020),
            ins(`MIE_OP_JUMP, 11'h002)});
        prog(13'h010, '{ins(`MIE_OP_LOAD_IMM, 11'h033), ins(`MIE_OP_RET, 11'h000)});
        prog(13'h020, '{ins(`MIE_OP_RET_IMM, 11'h05a)});
        run_test(13'h002, 8'h5a, 4'b0000, 4'b0000);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h001), ins(`MIE_OP_MOV_TO_REG, 11'h404),
            ins(`MIE_OP_LOAD_IMM, 11'h030), ins(`MIE_OP_MOV_TO_REG, 11'h402)});
        prog(13'h130, '{ins(`MIE_OP_JUMP, 11'h130)});
        run_test(13'h130, 8'h30, 4'b0000, 4'b0000);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h008), ins(`MIE_OP_MOV_TO_REG, 11'h404),
            ins(`MIE_OP_JUMP, 11'h03a)});
        prog(13'h83a, '{ins(`MIE_OP_JUMP, 11'h03a)});
        run_test(13'h83a, 8'h08, 4'b0000, 4'b0000);
        prog(13'h000, '{ins(`MIE_OP_LOAD_IMM, 11'h011), ins(`MIE_OP_MOV_TO_REG, 11'h420),
            ins(`MIE_OP_BIT_SET, 11'h703), ins(`MIE_OP_LOAD_IMM, 11'h022),
            ins(`MIE_OP_MOV_TO_REG, 11'h420), ins(`MIE_OP_BIT_CLR, 11'h703),
            ins(`MIE_OP_MOV_TO_ACC, 11'h020), ins(`MIE_OP_JUMP, 11'h007)});
        run_test(13'h007, 8'h11, 4'b0000, 4'b0000);
        irq_prog(8'h20);
        run_test(13'h018, 8'h99, 4'b0000, 4'b1100);
        irq_prog(8'h00);
        run_test(13'h018, 8'h00, 4'b0100, 4'b1100);
        summarize();
    end
endmodule : mcu_instruction_execute_test

`default_nettype wire

// File: dv/mie_prog_mem.sv
// Program memory model standing on the fetch side of the execute core
`timescale 1ns/1ps
`default_nettype none

module mie_prog_mem (
    input  wire logic [12:0] prog_addr,
    output logic      [15:0] prog_data
);
    logic [15:0] mem [0:8191];

    // Empty words read as no-operation, so a stray fetch does no harm
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
    end

    // Answer in the same cycle: the core executes the word it addresses
    assign prog_data = mem[prog_addr];
endmodule : mie_prog_mem

`default_nettype wire

// File: logic/mie_core.sv
// Instruction decode and execute core with AHB-Lite control port
`timescale 1ns/1ps
`default_nettype none
`include "mie_defs.svh"

module mie_core (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic [12:0]      prog_addr,
    input  wire logic [15:0] prog_data
);

    mie_pkg::mie_regs_type r;
    mie_pkg::mie_regs_type next_r;
    logic [7:0]            rf [0:`MIE_RF_DEPTH-1];

    logic [4:0]  op;
    logic        d;
    logic [2:0]  bi;
    logic [7:0]  a8;
    logic [10:0] a11;
    logic [7:0]  ridx;
    logic [7:0]  rv;
    logic [7:0]  a_in;
    logic [8:0]  add9;
    logic [4:0]  hadd;
    logic [8:0]  sub9;
    logic [4:0]  hsub;
    logic        irq_take;
    logic        exe;
    logic        rf_we;
    logic [7:0]  rf_wd;
    logic [7:0]  res;
    logic        wr;
    logic        to_reg;
    logic        upd_z;
    logic        upd_ch;
    logic        new_c;
    logic        new_hc;
    logic        skip;
    logic        addr_ph;

    assign op  = prog_data[15:11];
    assign d   = prog_data[10];
    assign bi  = prog_data[10:8];
    assign a8  = prog_data[7:0];
    assign a11 = prog_data[10:0];

    // Special registers stay visible in both banks so the bank bit can always be cleared
    assign ridx = r.status[`MIE_ST_BS] ? {`MIE_BANK1_BASE, a8[3:0]} : {1'b0, a8[6:0]};

    always_comb begin
        case (a8)
            `MIE_A_TIMER:  rv = r.timer;
            `MIE_A_PCL:    rv = r.pc[7:0];
            `MIE_A_STATUS: rv = r.status;
            `MIE_A_PC_PAGE_BUFFER: rv = {3'h0, r.pc_page_buffer};
            `MIE_A_IRQ_ENABLE_REG:  rv = r.irq_enable_reg;
            `MIE_A_INDIRECT_ADDR_REG:  rv = r.indirect_addr_reg;
            default:       rv = rf[ridx];
        endcase
    end

    assign a_in = (op == `MIE_OP_ADD_IMM || op == `MIE_OP_SUB_IMM) ? a8 : rv;
    assign add9 = {1'b0, a_in} + {1'b0, r.acc};
    assign hadd = {1'b0, a_in[3:0]} + {1'b0, r.acc[3:0]};
    assign sub9 = {1'b0, a_in} - {1'b0, r.acc};
    assign hsub = {1'b0, a_in[3:0]} - {1'b0, r.acc[3:0]};

    assign irq_take = r.run && r.state == mie_pkg::mie_exec && r.irq_enable_reg[`MIE_IE_TOE]
                      && r.irq_enable_reg[`MIE_IE_TOF] && !r.in_isr;
    assign exe      = r.run && r.state == mie_pkg::mie_exec && !irq_take;
    assign addr_ph  = hsel && hready && htrans[1];

    always_comb begin
        next_r = r;
        rf_we  = 1'b0;
        rf_wd  = 8'h00;
        res    = 8'h00;
        wr     = 1'b0;
        to_reg = d;
        upd_z  = 1'b0;
        upd_ch = 1'b0;
        new_c  = r.status[`MIE_ST_C];
        new_hc = r.status[`MIE_ST_HC];
        skip   = 1'b0;

        if (r.run) begin
            next_r.timer = r.timer + 8'h01;
            next_r.state = mie_pkg::mie_exec;
        end

        if (irq_take) begin
            next_r.stack[r.sp] = r.pc;
            next_r.sp          = r.sp + 2'h1;
            next_r.pc          = `MIE_IRQ_VEC;
            next_r.in_isr      = 1'b1;
            next_r.state       = mie_pkg::mie_flush;
        end else if (exe) begin
            next_r.pc = r.pc + 13'h0001;
            case (op)
                `MIE_OP_ADD_REG, `MIE_OP_ADD_IMM: begin
                    res    = add9[7:0];
                    wr     = 1'b1;
                    to_reg = (op == `MIE_OP_ADD_REG) && d;
                    upd_z  = 1'b1;
                    upd_ch = 1'b1;
                    new_c  = add9[8];
                    new_hc = hadd[4];
                end
                `MIE_OP_SUB_REG, `MIE_OP_SUB_IMM: begin
                    res    = sub9[7:0];
                    wr     = 1'b1;
                    to_reg = (op == `MIE_OP_SUB_REG) && d;
                    upd_z  = 1'b1;
                    upd_ch = 1'b1;
                    new_c  = !sub9[8];
                    new_hc = !hsub[4];
                end
                `MIE_OP_INC, `MIE_OP_DEC: begin
                    res   = (op == `MIE_OP_INC) ? rv + 8'h01 : rv - 8'h01;
                    wr    = 1'b1;
                    upd_z = 1'b1;
                end
                `MIE_OP_INC_SZ, `MIE_OP_DEC_SZ: begin
                    res  = (op == `MIE_OP_INC_SZ) ? rv + 8'h01 : rv - 8'h01;
                    wr   = 1'b1;
                    skip = (res == 8'h00);
                end
                `MIE_OP_ZERO_REG, `MIE_OP_ZERO_ACC: begin
                    res    = 8'h00;
                    wr     = 1'b1;
                    to_reg = (op == `MIE_OP_ZERO_REG);
                    upd_z  = 1'b1;
                end
                `MIE_OP_AND_REG, `MIE_OP_AND_IMM: begin
                    res    = r.acc & ((op == `MIE_OP_AND_IMM) ? a8 : rv);
                    wr     = 1'b1;
                    to_reg = (op == `MIE_OP_AND_REG) && d;
                    upd_z  = 1'b1;
                end
                `MIE_OP_INVERT: begin
                    res   = rv ^ 8'hff;
                    wr    = 1'b1;
                    upd_z = 1'b1;
                end
                `MIE_OP_OR_REG, `MIE_OP_OR_IMM: begin
                    res    = r.acc | ((op == `MIE_OP_OR_IMM) ? a8 : rv);
                    wr     = 1'b1;
                    to_reg = (op == `MIE_OP_OR_REG) && d;
                    upd_z  = 1'b1;
                end
                `MIE_OP_XOR_REG, `MIE_OP_XOR_IMM: begin
                    res    = r.acc ^ ((op == `MIE_OP_XOR_IMM) ? a8 : rv);
                    wr     = 1'b1;
                    to_reg = (op == `MIE_OP_XOR_REG) && d;
                    upd_z  = 1'b1;
                end
                `MIE_OP_BIT_CLR, `MIE_OP_BIT_SET: begin
                    res    = (op == `MIE_OP_BIT_SET) ? rv | (8'h01 << bi)
                                                     : rv & ~(8'h01 << bi);
                    wr     = 1'b1;
                    to_reg = 1'b1;
                end
                `MIE_OP_TST_CLR: skip = !rv[bi];
                `MIE_OP_TST_SET: skip = rv[bi];
                `MIE_OP_MOV_TO_REG: begin
                    res    = r.acc;
                    wr     = 1'b1;
                    to_reg = 1'b1;
                end
                `MIE_OP_MOV_TO_ACC: begin
                    res    = rv;
                    wr     = 1'b1;
                    to_reg = 1'b0;
                    upd_z  = 1'b1;
                end
                `MIE_OP_LOAD_IMM: begin
                    res    = a8;
                    wr     = 1'b1;
                    to_reg = 1'b0;
                end
                `MIE_OP_SWAP: begin
                    res = {rv[3:0], rv[7:4]};
                    wr  = 1'b1;
                end
                `MIE_OP_ROT_LEFT: begin
                    res   = {rv[6:0], r.status[`MIE_ST_C]};
                    wr    = 1'b1;
                    new_c = rv[7];
                end
                `MIE_OP_ROT_RIGHT: begin
                    res   = {r.status[`MIE_ST_C], rv[7:1]};
                    wr    = 1'b1;
                    new_c = rv[0];
                end
                `MIE_OP_CALL, `MIE_OP_JUMP: begin
                    if (op == `MIE_OP_CALL) begin
                        next_r.stack[r.sp] = r.pc + 13'h0001;
                        next_r.sp          = r.sp + 2'h1;
                    end
                    next_r.pc    = {r.pc_page_buffer[4:3], a11};
                    next_r.state = mie_pkg::mie_flush;
                end
                `MIE_OP_RET_IMM, `MIE_OP_RET: begin
                    next_r.sp    = r.sp - 2'h1;
                    next_r.pc    = r.stack[r.sp - 2'h1];
                    next_r.state = mie_pkg::mie_flush;
                    if (op == `MIE_OP_RET_IMM) begin
                        next_r.acc = a8;
                    end
                    if (op == `MIE_OP_RET && d) begin
                        next_r.in_isr = 1'b0;
                    end
                end
                default: ;
            endcase

            if (wr && !to_reg) begin
                next_r.acc = res;
            end else if (wr) begin
                case (a8)
                    `MIE_A_TIMER:  next_r.timer = res;
                    `MIE_A_PCL: begin
                        next_r.pc    = {r.pc_page_buffer, res};
                        next_r.state = mie_pkg::mie_flush;
                    end
                    `MIE_A_STATUS: next_r.status = res;
                    `MIE_A_PC_PAGE_BUFFER: next_r.pc_page_buffer = res[4:0];
                    `MIE_A_IRQ_ENABLE_REG:  next_r.irq_enable_reg = res;
                    `MIE_A_INDIRECT_ADDR_REG:  next_r.indirect_addr_reg = res;
                    default: begin
                        rf_we = 1'b1;
                        rf_wd = res;
                    end
                endcase
            end

            if (upd_z) begin
                next_r.status[`MIE_ST_Z] = (res == 8'h00);
            end
            if (upd_ch) begin
                next_r.status[`MIE_ST_HC] = new_hc;
            end
            // Carry is only touched by ops that own it, so a bit op on the status register sticks
            if (upd_ch || op == `MIE_OP_ROT_LEFT || op == `MIE_OP_ROT_RIGHT) begin
                next_r.status[`MIE_ST_C] = new_c;
            end

            if (skip) begin
                next_r.pc    = r.pc + 13'h0002;
                next_r.state = mie_pkg::mie_flush;
            end
        end

        // Overflow set is applied last so it wins over a clear in the same cycle
        if (r.run && r.timer == 8'hff) begin
            next_r.irq_enable_reg[`MIE_IE_TOF] = 1'b1;
        end

        if (r.wpend && r.waddr == `MIE_CTRL_OFF) begin
            next_r.run = hwdata[`MIE_CTRL_RUN];
        end
        next_r.wpend = addr_ph && hwrite;
        if (addr_ph) begin
            next_r.waddr = haddr[7:0];
        end
        if (addr_ph && !hwrite) begin
            case (haddr[7:0])
                `MIE_CTRL_OFF: next_r.hrdata = {31'h0, r.run};
                `MIE_STAT_OFF: next_r.hrdata = {4'h0, r.in_isr, r.status[2:0], r.acc,
                                                3'h0, r.pc};
                default:       next_r.hrdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.state <= mie_pkg::mie_exec;
            r.pc <= `MIE_PC_RESET;
            r.run <= `MIE_CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Register file holds no reset: firmware initialises what it uses
    always_ff @(posedge hclk) begin
        if (rf_we) begin
            rf[ridx] <= rf_wd;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = r.hrdata;
    assign prog_addr = r.pc;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_vector;
        irq_take |=> prog_addr == `MIE_IRQ_VEC && r.in_isr;
    endproperty
    a_vector: assert property (p_vector) else $error("no vector on timer irq");

    property p_mask;
        !r.irq_enable_reg[`MIE_IE_TOE] |-> !irq_take;
    endproperty
    a_mask: assert property (p_mask) else $error("irq taken while disabled");

    property p_overflow;
        r.run && r.timer == 8'hff |=> r.irq_enable_reg[`MIE_IE_TOF] && r.timer == 8'h00;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flag not set");

    property p_add;
        exe && op == `MIE_OP_ADD_IMM |=> r.acc == $past(add9[7:0])
            && r.status[`MIE_ST_C] == $past(add9[8]) && r.status[`MIE_ST_Z] == (r.acc == 8'h00);
    endproperty
    a_add: assert property (p_add) else $error("add result or flags wrong");

    property p_sub_carry;
        exe && op == `MIE_OP_SUB_IMM |=> r.status[`MIE_ST_C] == ($past(a8) >= $past(r.acc));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("sub carry wrong");

    property p_skip;
        exe && (op == `MIE_OP_INC_SZ && rv == 8'hff || op == `MIE_OP_DEC_SZ && rv == 8'h01)
            |=> r.state == mie_pkg::mie_flush
            && r.pc == $past(r.pc) + 13'h0002 && r.status[2:0] == $past(r.status[2:0]);
    endproperty
    a_skip: assert property (p_skip) else $error("skip not taken");

    property p_jump;
        exe && op == `MIE_OP_JUMP |=> r.pc == {$past(r.pc_page_buffer[4:3]), $past(a11)}
            && r.state == mie_pkg::mie_flush;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target or timing wrong");

    property p_pcl;
        exe && wr && to_reg && a8 == `MIE_A_PCL && !skip |=> r.pc[12:8] == $past(r.pc_page_buffer);
    endproperty
    a_pcl: assert property (p_pcl) else $error("page buffer not used");

    property p_bit_flags;
        exe && op == `MIE_OP_BIT_SET && a8 != `MIE_A_STATUS
            |=> r.status[2:0] == $past(r.status[2:0]);
    endproperty
    a_bit_flags: assert property (p_bit_flags) else $error("bit op changed flags");

    c_irq:  cover property (irq_take ##2 exe);
    c_skip: cover property (exe && skip);
    c_call: cover property (exe && op == `MIE_OP_CALL);
    c_return_from_timer_irq: cover property (exe && op == `MIE_OP_RET && d);

endmodule : mie_core

`default_nettype wire
